// *** msoc_pkg.sv ***
/*
 * Shared constants and types of the meter switch output controller.
 * Assumes a single 25 MHz device clock and two switch outputs.
 */
package msoc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned ON_TIME_UNIT_S = 1;
    localparam int unsigned SEC_CYC = CLK_HZ * ON_TIME_UNIT_S;

    // ************************************************************
    // Sizes and limits
    // ************************************************************
    localparam int unsigned NUM_OUT = 2;
    localparam int unsigned ON_TIME_W = 14;
    localparam int unsigned CYC_W = 25;
    localparam int unsigned RATE_W = 16;
    localparam int unsigned ASSOC_W = 4;
    localparam logic [ON_TIME_W-1:0] ON_TIME_MAX = 14'h270f;

    // ************************************************************
    // Modes
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_REMOTE = 2'h0,
        SRC_DEMAND = 2'h1,
        SRC_ALARM = 2'h2,
        SRC_ENERGY = 2'h3
    } msoc_src_type;

    typedef enum logic [1:0] {
        BEH_LATCH = 2'h0,
        BEH_TIMED = 2'h1,
        BEH_HOLD = 2'h2
    } msoc_beh_type;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        msoc_src_type src;
        msoc_beh_type beh;
        logic [ON_TIME_W-1:0] on_time;
        logic [RATE_W-1:0] rate_div;
    } msoc_cfg_type;

    typedef struct packed {
        logic on;
        logic off;
        logic energize;
        logic release_hold;
    } msoc_cmd_type;

    typedef struct packed {
        logic on;
        logic run;
        logic pend;
        logic [ON_TIME_W-1:0] sec_left;
        logic [CYC_W-1:0] cyc;
        logic [RATE_W-1:0] div_cnt;
    } msoc_ch_type;

    typedef struct packed {
        msoc_ch_type [NUM_OUT-1:0] ch;
        logic [NUM_OUT-1:0] held;
        logic [NUM_OUT-1:0] err;
        logic [NUM_OUT-1:0][ASSOC_W-1:0] assoc;
        logic restored;
    } msoc_state_type;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam msoc_state_type STATE_RESET = '0;

endpackage : msoc_pkg

// *** msoc_switch_out.sv ***
/*
 * Two switch outputs of an energy meter, each driven by remote
 * commands, demand interval ends, alarm triggers or energy pulses,
 * shaped as latched, timed or coil-hold behaviour.
 * Assumes all inputs synchronous to CLK_I; command, trigger and
 * energy inputs are one-cycle pulses; HOLD_NV_I holds the saved
 * coil-hold state from non-volatile storage when reset is released.
 */
//
// Behaviour
// (R1) Two outputs, each with its own source and behaviour setting.
// (R2) Remote source: only on/off commands change the output; the code uses energize/release in coil-hold and ends timed pulses itself.
// (R3) Demand source: one pulse per demand interval end.
// (R4) Downstream meter takes each sync pulse as its period boundary.
// (R5) Alarm source: a pulse whenever the alarm triggers.
// (R6) Energy source: pulse at configured rate per energy unit.
// (R7) Receiver counts pulses to derive consumed energy.
// (R8) Latched and coil-hold only with remote or alarm source.
// (R9) Latched: stays on until an off command.
// (R10) Timed: on for 0 to 9999 whole seconds, then off.
// (R11) Coil-hold: energize turns on, hold-release turns off.
// (R12) Coil-hold state survives power loss and is restored.
// (R13) Configurer uses coil-hold for unary alarm outputs.
// (R14) Report which meter function each output is associated with.
// (R15) Configurer enables an alarm before associating an output.
// (R16) Demand and alarm pulses last on time, not extended.
`timescale 1ns/1ps
module msoc_switch_out
    import msoc_pkg::*;
#(
    parameter int unsigned TICK_CYC = SEC_CYC
)
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire msoc_cfg_type [NUM_OUT-1:0] CFG_I,
    input wire msoc_cmd_type [NUM_OUT-1:0] CMD_I,
    input wire logic [NUM_OUT-1:0] DEMAND_END_I,
    input wire logic [NUM_OUT-1:0] ALARM_TRIG_I,
    input wire logic [NUM_OUT-1:0] ENERGY_INC_I,
    input wire logic [NUM_OUT-1:0] HOLD_NV_I,
    output logic FIRST_SWITCH_OUTPUT_O,
    output logic SECOND_SWITCH_OUTPUT_O,
    output logic [NUM_OUT-1:0] HOLD_STATE_O,
    output logic [NUM_OUT-1:0] CFG_ERR_O,
    output logic [NUM_OUT-1:0][ASSOC_W-1:0] ASSOC_O
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    localparam logic [CYC_W-1:0] TICK_LAST = CYC_W'(TICK_CYC - 1);

    if ((TICK_CYC < 1) || (TICK_CYC > (2 ** CYC_W)))
    begin : g_bad_tick
        $error("TICK_CYC out of range");
    end

    // ************************************************************
    // State
    // ************************************************************
    msoc_state_type s_r;
    msoc_state_type s_nxt;

    always_comb
    begin
        msoc_cfg_type c;
        msoc_cmd_type k;
        msoc_ch_type n;
        msoc_beh_type beh;
        logic bad;
        logic busy;
        logic fire;
        logic start;
        logic [RATE_W-1:0] rate;
        logic [ON_TIME_W-1:0] len;
        c = '0;
        k = '0;
        n = '0;
        beh = BEH_LATCH;
        bad = 1'b0;
        busy = 1'b0;
        fire = 1'b0;
        start = 1'b0;
        rate = '0;
        len = '0;
        s_nxt = s_r;
        s_nxt.restored = 1'b1;
        for (int i = 0; i < NUM_OUT; i++)
        begin
            c = CFG_I[i];
            k = CMD_I[i];
            n = s_r.ch[i];
            busy = s_r.ch[i].run;
            fire = 1'b0;
            start = 1'b0;
            // Latched and hold fall back to timed when not allowed
            bad = ((c.src == SRC_DEMAND) || (c.src == SRC_ENERGY))
                && (c.beh != BEH_TIMED); // [R8]
            beh = bad ? BEH_TIMED : c.beh; // [R8]
            len = (c.on_time > ON_TIME_MAX) ? ON_TIME_MAX : c.on_time;
            rate = (c.rate_div == '0) ? 16'h1 : c.rate_div;
            // Seconds countdown of a running pulse
            if (n.run)
            begin
                if (n.sec_left == '0)
                begin
                    n.run = 1'b0; // [R10]
                    n.on = 1'b0; // [R10]
                end
                else if (n.cyc == TICK_LAST)
                begin
                    n.cyc = '0;
                    n.sec_left = n.sec_left - 14'h1; // [R10]
                end
                else
                begin
                    n.cyc = n.cyc + 25'h1;
                end
            end
            // Energy increments divided down to output pulses
            if ((c.src == SRC_ENERGY) && ENERGY_INC_I[i])
            begin
                if ((n.div_cnt + 16'h1) >= rate)
                begin
                    n.div_cnt = '0;
                    fire = 1'b1; // [R6]
                end
                else
                begin
                    n.div_cnt = n.div_cnt + 16'h1;
                end
            end
            // Source and behaviour dispatch
            case (c.src)
                SRC_REMOTE:
                begin
                    case (beh)
                        BEH_LATCH:
                        begin
                            if (k.off)
                            begin
                                n.on = 1'b0; // [R9]
                                n.run = 1'b0;
                            end
                            if (k.on)
                            begin
                                n.on = 1'b1; // [R2]
                                n.run = 1'b0;
                            end
                        end
                        BEH_TIMED:
                        begin
                            if (k.off)
                            begin
                                n.on = 1'b0; // [R2]
                                n.run = 1'b0;
                            end
                            start = k.on && !busy; // [R2]
                        end
                        BEH_HOLD:
                        begin
                            if (k.release_hold)
                            begin
                                n.on = 1'b0; // [R11]
                                n.run = 1'b0;
                            end
                            if (k.energize)
                            begin
                                n.on = 1'b1; // [R11]
                                n.run = 1'b0;
                            end
                        end
                        default:
                        begin
                            n.on = 1'b0;
                        end
                    endcase
                end
                SRC_ALARM:
                begin
                    case (beh)
                        BEH_LATCH:
                        begin
                            if (k.off)
                            begin
                                n.on = 1'b0; // [R9]
                                n.run = 1'b0;
                            end
                            if (ALARM_TRIG_I[i])
                            begin
                                n.on = 1'b1; // [R5]
                                n.run = 1'b0;
                            end
                        end
                        BEH_TIMED:
                        begin
                            start = ALARM_TRIG_I[i] && !busy; // [R5] [R16]
                        end
                        BEH_HOLD:
                        begin
                            if (k.release_hold)
                            begin
                                n.on = 1'b0; // [R11]
                                n.run = 1'b0;
                            end
                            if (k.energize || ALARM_TRIG_I[i])
                            begin
                                n.on = 1'b1; // [R11]
                                n.run = 1'b0;
                            end
                        end
                        default:
                        begin
                            n.on = 1'b0;
                        end
                    endcase
                end
                SRC_DEMAND:
                begin
                    start = DEMAND_END_I[i] && !busy; // [R3] [R16]
                end
                SRC_ENERGY:
                begin
                    if (!busy && (fire || n.pend))
                    begin
                        start = 1'b1; // [R6]
                        n.pend = 1'b0;
                    end
                    else if (fire)
                    begin
                        n.pend = 1'b1; // [R6]
                    end
                end
                default:
                begin
                    start = 1'b0;
                end
            endcase
            if (start)
            begin
                n.on = 1'b1;
                n.run = 1'b1;
                n.sec_left = len; // [R10]
                n.cyc = '0;
            end
            if (c.src != SRC_ENERGY)
            begin
                n.pend = 1'b0;
                n.div_cnt = '0;
            end
            // Saved coil-hold state taken back after power returns
            if (!s_r.restored && (beh == BEH_HOLD))
            begin
                n.on = HOLD_NV_I[i]; // [R12]
                n.run = 1'b0;
            end
            s_nxt.ch[i] = n;
            s_nxt.held[i] = n.on && (beh == BEH_HOLD); // [R12]
            s_nxt.err[i] = bad; // [R8]
            s_nxt.assoc[i] = 4'h1 << c.src; // [R14]
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_r <= STATE_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign FIRST_SWITCH_OUTPUT_O = s_r.ch[0].on; // [R1]
    assign SECOND_SWITCH_OUTPUT_O = s_r.ch[1].on; // [R1]
    assign HOLD_STATE_O = s_r.held;
    assign CFG_ERR_O = s_r.err;
    assign ASSOC_O = s_r.assoc;

    // ************************************************************
    // Checks per output
    // ************************************************************
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_chk
        a_latch_off_cmd: assert property (@(posedge CLK_I) // [R9]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_REMOTE)
            && (CFG_I[g].beh == BEH_LATCH) && CMD_I[g].off
            && !CMD_I[g].on) |=> !s_r.ch[g].on)
        else $error("latched output not cleared by off");

        a_latch_stays_on: assert property (@(posedge CLK_I) // [R2]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_REMOTE)
            && (CFG_I[g].beh == BEH_LATCH) && s_r.ch[g].on
            && !s_r.ch[g].run && !CMD_I[g].off) |=> s_r.ch[g].on)
        else $error("latched output dropped without off");

        a_demand_pulse: assert property (@(posedge CLK_I) // [R3]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_DEMAND)
            && DEMAND_END_I[g] && !s_r.ch[g].run)
            |=> (s_r.ch[g].on && s_r.ch[g].run
            && (s_r.ch[g].sec_left == $past(CFG_I[g].on_time))))
        else $error("demand end gave no pulse");

        a_alarm_pulse: assert property (@(posedge CLK_I) // [R5]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_ALARM)
            && (CFG_I[g].beh == BEH_TIMED) && ALARM_TRIG_I[g]
            && !s_r.ch[g].run) |=> (s_r.ch[g].on && s_r.ch[g].run))
        else $error("alarm trigger gave no pulse");

        a_no_extend: assert property (@(posedge CLK_I) // [R16]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_DEMAND)
            && s_r.ch[g].run && (s_r.ch[g].sec_left == '0))
            |=> (!s_r.ch[g].on && !s_r.ch[g].run))
        else $error("demand pulse extended past on time");

        a_sec_countdown: assert property (@(posedge CLK_I) // [R10]
            disable iff (!RST_N_I)
            (s_r.restored && s_r.ch[g].run && !DEMAND_END_I[g]
            && (s_r.ch[g].sec_left != '0)
            && (s_r.ch[g].cyc == TICK_LAST) && !CMD_I[g].off)
            |=> (s_r.ch[g].sec_left == ($past(s_r.ch[g].sec_left)
            - 14'h1)) && (s_r.ch[g].cyc == '0))
        else $error("on time countdown wrong");

        a_bad_combo: assert property (@(posedge CLK_I) // [R8]
            disable iff (!RST_N_I)
            (((CFG_I[g].src == SRC_DEMAND)
            || (CFG_I[g].src == SRC_ENERGY))
            && (CFG_I[g].beh != BEH_TIMED))
            |=> (CFG_ERR_O[g] && !HOLD_STATE_O[g]))
        else $error("disallowed behaviour accepted");

        a_hold_release: assert property (@(posedge CLK_I) // [R11]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_REMOTE)
            && (CFG_I[g].beh == BEH_HOLD) && CMD_I[g].release_hold
            && !CMD_I[g].energize) |=> (!s_r.ch[g].on && !s_r.held[g]))
        else $error("coil hold not released");

        a_energy_fire: assert property (@(posedge CLK_I) // [R6]
            disable iff (!RST_N_I)
            (s_r.restored && (CFG_I[g].src == SRC_ENERGY)
            && (CFG_I[g].rate_div <= 16'h1) && ENERGY_INC_I[g]
            && !s_r.ch[g].run) |=> s_r.ch[g].run)
        else $error("energy increment gave no pulse");

        a_hold_restore: assert property (@(posedge CLK_I) // [R12]
            disable iff (!RST_N_I)
            (!s_r.restored && (CFG_I[g].src == SRC_REMOTE)
            && (CFG_I[g].beh == BEH_HOLD))
            |=> (s_r.ch[g].on == $past(HOLD_NV_I[g])))
        else $error("coil hold state not restored");

        a_assoc_report: assert property (@(posedge CLK_I) // [R14]
            disable iff (!RST_N_I)
            s_r.restored |=> (ASSOC_O[g] == (4'h1 << $past(CFG_I[g].src))))
        else $error("association report wrong");
    end

endmodule : msoc_switch_out

// *** msoc_pulse_rx.sv ***
/*
 * Pulse receiver standing at a switch output: a relay, PLC or a
 * downstream meter input that counts each pulse it sees.
 * Assumes the watched output is a level synchronous to CLK_I.
 */
`timescale 1ns/1ps
module msoc_pulse_rx
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic PULSE_I,
    output logic [15:0] COUNT_O
);
    // ************************************************************
    // Rising edge counter
    // ************************************************************
    logic last_r;

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            last_r <= 1'b0;
            COUNT_O <= 16'h0;
        end
        else
        begin
            last_r <= PULSE_I;
            if (PULSE_I && !last_r)
            begin
                COUNT_O <= COUNT_O + 16'h1;
            end
        end
    end
endmodule : msoc_pulse_rx

// *** meter_switch_output_control_test.sv ***
/*
 * Self-checking bench of the switch output controller.
 * Assumes the design package and a short seconds tick in simulation.
 */
`timescale 1ns/1ps
module meter_switch_output_control_test
    import msoc_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam int TICK = 4;
    logic clk_i;
    logic rst_n_i;
    msoc_cfg_type [NUM_OUT-1:0] cfg;
    msoc_cmd_type [NUM_OUT-1:0] cmd;
    logic [NUM_OUT-1:0] dem;
    logic [NUM_OUT-1:0] alm;
    logic [NUM_OUT-1:0] eng;
    logic [NUM_OUT-1:0] hnv;
    logic sw0;
    logic sw1;
    logic [NUM_OUT-1:0] hs;
    logic [NUM_OUT-1:0] ce;
    logic [NUM_OUT-1:0][ASSOC_W-1:0] asc;
    logic [15:0] rx_cnt;
    int failures = 0;
    int n_tests = 0;
    int seed = 32'h2270;
    int w;
    int t;
    int c0;

    msoc_switch_out #(.TICK_CYC(TICK)) u_msoc_switch_out (
        .CLK_I(clk_i), .RST_N_I(rst_n_i), .CFG_I(cfg), .CMD_I(cmd),
        .DEMAND_END_I(dem), .ALARM_TRIG_I(alm), .ENERGY_INC_I(eng),
        .HOLD_NV_I(hnv), .FIRST_SWITCH_OUTPUT_O(sw0),
        .SECOND_SWITCH_OUTPUT_O(sw1), .HOLD_STATE_O(hs),
        .CFG_ERR_O(ce), .ASSOC_O(asc)
    );

    msoc_pulse_rx u_msoc_pulse_rx (
        .CLK_I(clk_i), .RST_N_I(rst_n_i), .PULSE_I(sw1), .COUNT_O(rx_cnt)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic logic sw(input int i);
        return (i != 0) ? sw1 : sw0;
    endfunction : sw

    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task setc(input int i, input int s, input int b, input int tm,
              input int r);
        @(posedge clk_i);
        cfg[i] <= '{src: msoc_src_type'(s), beh: msoc_beh_type'(b),
                    on_time: ON_TIME_W'(tm), rate_div: RATE_W'(r)};
        repeat (2) @(posedge clk_i);
    endtask : setc

    // Kinds: 0 on, 1 off, 2 energize, 3 release, 4 demand, 5 alarm, 6 energy
    task kick(input int k, input int i);
        @(posedge clk_i);
        case (k)
            0: cmd[i].on <= 1'b1;
            1: cmd[i].off <= 1'b1;
            2: cmd[i].energize <= 1'b1;
            3: cmd[i].release_hold <= 1'b1;
            4: dem[i] <= 1'b1;
            5: alm[i] <= 1'b1;
            default: eng[i] <= 1'b1;
        endcase
        @(posedge clk_i);
        cmd[i] <= '0;
        dem[i] <= 1'b0;
        alm[i] <= 1'b0;
        eng[i] <= 1'b0;
    endtask : kick

    task settle;
        repeat (2) @(negedge clk_i);
    endtask : settle

    task width(input int i, output int n);
        int g;
        n = 0;
        g = 0;
        do
        begin
            @(negedge clk_i);
            g++;
        end
        while (sw(i) !== 1'b1 && g < 40);
        if (g >= 40)
        begin
            failures++;
            end_of_test();
        end
        while (sw(i) === 1'b1 && n < 50000)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : width

    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        rst_n_i = 1'b0;
        cfg = '0;
        cmd = '0;
        dem = '0;
        alm = '0;
        eng = '0;
        hnv = '0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        setc(1, 3, 1, 0, 1);
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 3; b++)
            begin
                setc(0, s, b, 0, 1);
                settle();
                check(32'(asc[0]), 32'h1 << s);
                check(32'(ce[0]), 32'((b != 1) && (s % 2 == 1)));
                check(32'(asc[1]), 32'h8);
            end
        $display("Test association done");
        setc(0, 0, 0, 0, 1);
        kick(1, 0);
        kick(0, 0);
        kick(2, 0);
        kick(4, 0);
        repeat (10) @(posedge clk_i);
        settle();
        check(32'(sw0), 32'h1);
        kick(1, 0);
        settle();
        check(32'(sw0), 32'h0);
        $display("Test remote latched done");
        for (int n = 0; n < 4; n++)
        begin
            t = $random(seed) & 3;
            setc(n % 2, (n % 2) ? 1 : 2, 1, t, 1);
            kick((n % 2) ? 4 : 5, n % 2);
            fork
                width(n % 2, w);
                begin
                    repeat (3) @(posedge clk_i);
                    kick((n % 2) ? 4 : 5, n % 2);
                end
            join
            check(w, t * TICK + 1);
            repeat (30) @(posedge clk_i);
        end
        $display("Test timed pulses done");
        setc(0, 2, 0, 0, 1);
        kick(5, 0);
        repeat (12) @(posedge clk_i);
        settle();
        check(32'(sw0), 32'h1);
        kick(1, 0);
        settle();
        check(32'(sw0), 32'h0);
        $display("Test alarm latched done");
        setc(0, 0, 1, 1, 1);
        kick(0, 0);
        settle();
        check(32'(sw0), 32'h1);
        kick(1, 0);
        settle();
        check(32'(sw0), 32'h0);
        $display("Test remote timed done");
        setc(0, 0, 2, 0, 1);
        kick(0, 0);
        settle();
        check(32'(sw0), 32'h0);
        kick(2, 0);
        settle();
        check(32'(sw0), 32'h1);
        check(32'(hs[0]), 32'h1);
        @(posedge clk_i);
        hnv <= hs;
        rst_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        check(32'(sw0), 32'h0);
        rst_n_i <= 1'b1;
        settle();
        check(32'(sw0), 32'h1);
        kick(3, 0);
        settle();
        check(32'(sw0), 32'h0);
        check(32'(hs[0]), 32'h0);
        setc(1, 2, 2, 0, 1);
        kick(5, 1);
        settle();
        check(32'(sw1), 32'h1);
        check(32'(hs[1]), 32'h1);
        kick(3, 1);
        settle();
        check(32'(sw1), 32'h0);
        $display("Test coil hold done");
        setc(1, 3, 1, 0, 3);
        c0 = rx_cnt;
        repeat (6)
        begin
            kick(6, 1);
            repeat (3) @(posedge clk_i);
        end
        settle();
        check(32'(rx_cnt) - 32'(c0), 32'h2);
        $display("Test energy pulsing done");
        end_of_test();
    end
endmodule : meter_switch_output_control_test
